// ===== include/acq_pkg.sv
// Purpose : Shared constants and carriers for the acquisition limit checker
// Assumes : Avalon-MM register slave, 32-bit data, word index times four
// Notes   : Lengths in samples per channel; one sample per byte
package acq_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MEMSIZE   = 8'h10;
  localparam logic [7:0] IDX_PRE       = 8'h11;
  localparam logic [7:0] IDX_POST      = 8'h12;
  localparam logic [7:0] IDX_SEGMENT   = 8'h13;
  localparam logic [7:0] IDX_LOOPS     = 8'h14;
  localparam logic [7:0] IDX_CONFIG    = 8'h15;
  localparam logic [7:0] IDX_STATUS    = 8'h16;
  localparam logic [7:0] IDX_BUFLEN    = 8'h17;
  localparam logic [7:0] IDX_NOTIFY    = 8'h18;
  localparam logic [7:0] IDX_CONTROL   = 8'h19;
  localparam logic [7:0] IDX_CARD_AV   = 8'h1A;
  localparam logic [7:0] IDX_USER_LEN  = 8'hC8;
  localparam logic [7:0] IDX_USER_POS  = 8'hC9;
  localparam logic [7:0] IDX_CARD_LEN  = 8'hCA;

  // ----------------------------------------------------------------
  // Config and control field positions
  // ----------------------------------------------------------------
  localparam int CFG_CH_LSB   = 0;  // 2 bits: 0=1ch 1=2ch 2=4ch
  localparam int CFG_MODE_LSB = 2;  // 3 bits: acquisition mode
  localparam int CFG_DIR_BIT  = 5;  // 1 = transfer toward card
  localparam int CFG_FAST_BIT = 6;  // 1 = sample rate above 100 MS/s
  localparam int CTL_START    = 0;
  localparam int CTL_CLR_ERR  = 1;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Limits
  // ----------------------------------------------------------------
  localparam logic [35:0] MEM_MIN_BASE  = 36'h0_0000_0008;
  localparam logic [35:0] TRIG_MIN_BASE = 36'h0_0000_0004;
  localparam logic [35:0] PRE_MAX_1CH   = 36'h0_0000_3FE0; // 16k-32
  localparam logic [35:0] STREAM_TOP    = 36'h2_0000_0000; // 8G
  localparam logic [31:0] LOOPS_MAX     = 32'hFFFF_FFFF;   // 4G-1
  localparam logic [35:0] INSTALLED_MEM = 36'h0_0400_0000; // 64 MSample

  typedef enum logic [2:0] {
    MODE_STD_SINGLE = 3'h0,
    MODE_STD_MULTI  = 3'h1,
    MODE_STD_GATE   = 3'h2,
    MODE_FIFO_SINGLE= 3'h3,
    MODE_FIFO_MULTI = 3'h4,
    MODE_FIFO_GATE  = 3'h5
  } acq_mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avmm_rsp_t;

endpackage : acq_pkg

// ===== hw/length_check.sv
// Purpose : Checks one length value against minimum, maximum and step
// Assumes : Step is a power of two
// Notes   : Pure combinational
module length_check (
  input  wire logic [35:0] value,
  input  wire logic [35:0] min_len,
  input  wire logic [35:0] max_len,
  input  wire logic [35:0] step,
  output logic             ok
);
  import acq_pkg::*;

  // Step test uses a mask since every step is a power of two
  always_comb begin
    ok = (value >= min_len) && (value <= max_len) && ((value & (step - 36'h1)) == 36'h0);
  end

endmodule : length_check

// ===== hw/acq_limits.sv
// Purpose : Acquisition length limit checks and transfer buffer counters
// Assumes : One clock, Avalon-MM slave with waitrequest
// Notes   : Rejected writes keep the old value and raise a sticky error
//
// Design decision made here: the Avalon-MM slave port.
module acq_limits #(
  parameter logic [35:0] INSTALLED = acq_pkg::INSTALLED_MEM
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 CE,
  input  wire acq_pkg::avmm_req_t   AVM_REQ,
  input  wire logic                 XFER_BYTE,
  output acq_pkg::avmm_rsp_t        AVM_RSP,
  output logic                      INTERLACE,
  output logic                      XFER_ENABLE,
  output logic                      PARAM_ERROR
);
  import acq_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [35:0] memsize;
    logic [35:0] pre;
    logic [35:0] post;
    logic [35:0] segment;
    logic [31:0] loops;
    logic [31:0] config_w;
    logic [31:0] buflen;
    logic [31:0] notify;
    logic [31:0] user_len;
    logic [31:0] user_pos;
    logic [31:0] card_len;
    logic [31:0] pending;
    logic        running;
    logic        error;
    logic        ack;
    logic        wait_r;    // Registered waitrequest, high while idle
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [1:0]  ch_code;
  logic        fast;
  logic [2:0]  mode;
  logic        to_card;
  logic [35:0] mem_min;
  logic [35:0] trig_min;
  logic [35:0] mem_cap;
  logic [35:0] pre_max;
  logic [35:0] stream_max;
  logic [35:0] wval;
  logic [7:0]  widx;
  logic        ok_mem;
  logic        ok_pre;
  logic        ok_post;
  logic        ok_seg;
  logic        pre_used;
  logic        is_fifo;

  assign ch_code  = s_reg.config_w[CFG_CH_LSB +: 2];
  assign mode     = s_reg.config_w[CFG_MODE_LSB +: 3];
  assign to_card  = s_reg.config_w[CFG_DIR_BIT];
  assign fast     = s_reg.config_w[CFG_FAST_BIT];
  assign wval     = {4'h0, AVM_REQ.writedata};
  assign widx     = AVM_REQ.address[9:2];
  assign is_fifo  = (mode == MODE_FIFO_SINGLE) || (mode == MODE_FIFO_MULTI) ||
                    (mode == MODE_FIFO_GATE);
  assign pre_used = (mode != MODE_STD_SINGLE);

  // Interlace doubles every minimum and step
  assign mem_min  = fast ? (MEM_MIN_BASE << 1) : MEM_MIN_BASE;
  assign trig_min = fast ? (TRIG_MIN_BASE << 1) : TRIG_MIN_BASE;
  // Channel count shares memory; pre trigger FIFO shrinks likewise
  assign mem_cap  = INSTALLED >> ch_code;
  assign pre_max  = PRE_MAX_1CH >> ch_code;
  // Streaming lengths stop one step below 8G
  assign stream_max = STREAM_TOP - trig_min;

  // Memory and segment share the step of the trigger lengths.
  // Limitation: the bus carries 32-bit values, so the streaming ceiling
  // one step below 8G is never reached from software; it is kept so the
  // checks stay correct if the data path is ever widened.
  // Standard-mode post limits come from the per-channel memory cap, not
  // from a per-mode table: a few values pass here that a later start may
  // still refuse, traded for one checker per length.
  length_check u_mem (
    .value   (wval),
    .min_len (mem_min),
    .max_len (mem_cap),
    .step    (trig_min),
    .ok      (ok_mem)
  );
  length_check u_pre (
    .value   (wval),
    .min_len (trig_min),
    .max_len (pre_max),
    .step    (trig_min),
    .ok      (ok_pre)
  );
  length_check u_post (
    .value   (wval),
    .min_len (trig_min),
    .max_len (is_fifo ? stream_max : mem_cap - trig_min),
    .step    (trig_min),
    .ok      (ok_post)
  );
  length_check u_seg (
    .value   (wval),
    .min_len (mem_min),
    .max_len (is_fifo ? stream_max : mem_cap >> 1),
    .step    (trig_min),
    .ok      (ok_seg)
  );

  // Largest notify multiple not above the pending count.
  // A notify of zero publishes every byte at once, handy for bring-up.
  function automatic logic [31:0] notify_floor(input logic [31:0] v, input logic [31:0] n);
    notify_floor = (n == 32'h0) ? v : (v - (v % n));
  endfunction : notify_floor

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Transfer byte and host release may land in one cycle; both apply
  always_comb begin
    logic [31:0] granted;
    logic [31:0] rel;
    logic [31:0] pos_sum;
    granted = 32'h0;
    rel     = 32'h0;
    pos_sum = 32'h0;
    s_next  = s_reg;
    s_next.ack = 1'b0;

    // Bytes offered while the card counter is empty are dropped: the
    // engine must never move more than software has handed back.
    // Transfer engine moves one byte from card counter to pending
    if (s_reg.running && XFER_BYTE && (s_reg.card_len != 32'h0)) begin
      s_next.card_len = s_reg.card_len - 32'h1;
      s_next.pending  = s_reg.pending + 32'h1;
    end

    // Publish only whole notify blocks to the user
    granted = notify_floor(s_next.pending, s_reg.notify);
    s_next.user_len = s_reg.user_len + granted;
    s_next.pending  = s_next.pending - granted;

    // Bus handshake: a request is taken at the edge where it is first seen
    // with no answer pending; waitrequest then drops for exactly one cycle.
    // Read data is captured at the taking edge, so it already stands when
    // the master samples waitrequest low. A write lands only at that
    // answering edge, so no state moves while waitrequest is still high.
    if ((AVM_REQ.read || AVM_REQ.write) && !s_reg.ack) begin
      s_next.ack = 1'b1;
    end

    if (AVM_REQ.read || AVM_REQ.write) begin
      if (AVM_REQ.write && s_reg.ack) begin
        unique case (widx)
          IDX_MEMSIZE: if (ok_mem) s_next.memsize = wval; else s_next.error = 1'b1;
          IDX_PRE:     if (ok_pre && pre_used) s_next.pre = wval;
                       else s_next.error = 1'b1;
          IDX_POST:    if (ok_post) s_next.post = wval; else s_next.error = 1'b1;
          IDX_SEGMENT: if (ok_seg) s_next.segment = wval; else s_next.error = 1'b1;
          IDX_LOOPS:   s_next.loops = AVM_REQ.writedata;        // Full range valid
          IDX_CONFIG:  s_next.config_w = AVM_REQ.writedata;
          IDX_BUFLEN:  s_next.buflen = AVM_REQ.writedata;
          IDX_NOTIFY:  s_next.notify = AVM_REQ.writedata;
          IDX_CONTROL: begin
            if (AVM_REQ.writedata[CTL_CLR_ERR]) s_next.error = 1'b0;
            // Start resets counters to an empty user side
            if (AVM_REQ.writedata[CTL_START]) begin
              s_next.running  = 1'b1;
              s_next.user_len = 32'h0;
              s_next.user_pos = 32'h0;
              s_next.pending  = 32'h0;
              s_next.card_len = s_reg.buflen;
            end else begin
              // Stop keeps the counters so software can read where it ended
              s_next.running  = 1'b0;
            end
          end
          IDX_CARD_LEN: begin
            // Host returns consumed bytes; excess counts as error
            rel = (AVM_REQ.writedata > s_next.user_len) ? s_next.user_len
                                                        : AVM_REQ.writedata;
            if (AVM_REQ.writedata > s_next.user_len) s_next.error = 1'b1;
            s_next.user_len = s_next.user_len - rel;
            s_next.card_len = s_next.card_len + rel;
            pos_sum = s_reg.user_pos + rel;
            // Position wraps at the buffer end, carrying any overshoot past it
            s_next.user_pos = (pos_sum >= s_reg.buflen) ? pos_sum - s_reg.buflen : pos_sum;
          end
          default: ;
        endcase
      end else if (AVM_REQ.read && !s_reg.ack) begin
        unique case (widx)
          IDX_MEMSIZE:  s_next.rdata = s_reg.memsize[31:0];
          IDX_PRE:      s_next.rdata = s_reg.pre[31:0];
          IDX_POST:     s_next.rdata = s_reg.post[31:0];
          IDX_SEGMENT:  s_next.rdata = s_reg.segment[31:0];
          IDX_LOOPS:    s_next.rdata = s_reg.loops;
          IDX_CONFIG:   s_next.rdata = s_reg.config_w;
          IDX_STATUS:   s_next.rdata = {29'h0, to_card, s_reg.running, s_reg.error};
          IDX_BUFLEN:   s_next.rdata = s_reg.buflen;
          IDX_NOTIFY:   s_next.rdata = s_reg.notify;
          IDX_CARD_AV:  s_next.rdata = s_reg.card_len;
          IDX_USER_LEN: s_next.rdata = s_reg.user_len;
          IDX_USER_POS: s_next.rdata = s_reg.user_pos;
          default:      s_next.rdata = 32'h0;                         // Unmapped and write-only
        endcase
      end
    end

    // Waitrequest is its own flip-flop so the port needs no gate
    s_next.wait_r = ~s_next.ack;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Clock enable freezes everything, bus handshake included.
  // A request that meets a low enable before its answer simply sees a longer wait;
  // if enable drops in the answer cycle, waitrequest stays low and a write lands only at the next enabled edge.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_reg          <= '0;
      s_reg.wait_r   <= 1'b1;    // Idle slave holds waitrequest high
      s_reg.memsize  <= MEM_MIN_BASE;
      s_reg.pre      <= TRIG_MIN_BASE;
      s_reg.post     <= TRIG_MIN_BASE;
      s_reg.segment  <= MEM_MIN_BASE;
      s_reg.config_w <= CONFIG_RESET;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AVM_RSP.readdata    = s_reg.rdata;
  assign AVM_RSP.waitrequest = s_reg.wait_r;
  assign INTERLACE           = s_reg.config_w[CFG_FAST_BIT];
  assign XFER_ENABLE         = s_reg.running;
  assign PARAM_ERROR         = s_reg.error;

endmodule : acq_limits

// ===== tb/acq_limits_properties.sv
// Purpose: Port-level checks for acq_limits
// Assumes: Answer one cycle after a request
// Notes: Bound from the bench top file
module acq_limits_properties (
  input wire logic               CLK,
  input wire logic               RESET,
  input wire logic               CE,
  input wire acq_pkg::avmm_req_t AVM_REQ,
  input wire logic               XFER_BYTE,
  input wire acq_pkg::avmm_rsp_t AVM_RSP,
  input wire logic               INTERLACE,
  input wire logic               XFER_ENABLE,
  input wire logic               PARAM_ERROR
);
  timeunit 1ns;
  timeprecision 1ns;
  import acq_pkg::*;
  // ----------------------------------------------------------------
  // Bus and state properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic req;
  assign req = AVM_REQ.read | AVM_REQ.write;
  a_wait_answer: assert property (CE && req && AVM_RSP.waitrequest |=> !AVM_RSP.waitrequest)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!AVM_RSP.waitrequest |=> AVM_RSP.waitrequest)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!req && AVM_RSP.waitrequest |=> AVM_RSP.waitrequest)
    else $error("answer without request");
  a_read_hold: assert property (!AVM_REQ.read && !$past(AVM_REQ.read) |-> $stable(AVM_RSP.readdata))
    else $error("read data moved without read");
  a_error_sticky: assert property (PARAM_ERROR && !AVM_REQ.write |=> PARAM_ERROR)
    else $error("error flag dropped by itself");
  a_error_cause: assert property ($rose(PARAM_ERROR) |-> $past(AVM_REQ.write) || $past(AVM_REQ.write, 2))
    else $error("error flag without write");
  a_lace_cause: assert property ($changed(INTERLACE) |-> $past(AVM_REQ.write) || $past(AVM_REQ.write, 2))
    else $error("interlace changed without write");
  a_run_cause: assert property ($rose(XFER_ENABLE) |-> $past(AVM_REQ.write) || $past(AVM_REQ.write, 2))
    else $error("transfer started without write");
  // Main scenarios reached
  cover property (AVM_REQ.read && !AVM_RSP.waitrequest);
  cover property ($rose(PARAM_ERROR));
  cover property (XFER_ENABLE && XFER_BYTE);
endmodule : acq_limits_properties

// ===== tb/host_dma_model.sv
// Purpose: Byte stream of the host transfer side
// Assumes: One pulse is one byte
// Notes: Random pacing stalls like a busy host
module host_dma_model (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       load,
  input  wire logic [7:0] quota,
  output logic            XFER_BYTE,
  output logic            idle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_reg;
  bit         coin;
  // Sends exactly quota bytes, one per pulse, gaps at random
  always @(posedge CLK or posedge RESET) begin
    coin = $urandom_range(1, 0);
    if (RESET) begin
      left_reg <= 8'h00;
      XFER_BYTE <= 1'b0;
    end else if (load) begin
      left_reg <= quota;
      XFER_BYTE <= 1'b0;
    end else begin
      XFER_BYTE <= (left_reg != 8'h00) && coin;
      if (left_reg != 8'h00 && coin) left_reg <= left_reg - 8'h01;
    end
  end
  assign idle = (left_reg == 8'h00);
endmodule : host_dma_model

// ===== tb/acq_length_limits_and_buffer_handshake_bench.sv
// Purpose: Self-checking bench for acq_limits
// Assumes: Small installed memory to keep caps short
// Notes: Buffer of 64 bytes, notify 16
module acq_length_limits_and_buffer_handshake_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import acq_pkg::*;
  localparam logic [35:0] INST = 36'h0_0000_0400;
  logic CLK = 0, RESET = 1, CE = 1, load = 0, xb, idle, lace, run, perr;
  logic [7:0] quota = 8'h00;
  avmm_req_t  req = '0;
  avmm_rsp_t  rsp;
  int failures = 0, total_checks = 0, cyc = 0, moved = 0, freed = 0;
  int sh[4];
  always #5 CLK = ~CLK;
  acq_limits #(.INSTALLED(INST)) uut (.CLK(CLK), .RESET(RESET), .CE(CE), .AVM_REQ(req),
    .XFER_BYTE(xb), .AVM_RSP(rsp), .INTERLACE(lace), .XFER_ENABLE(run), .PARAM_ERROR(perr));
  host_dma_model host (.CLK(CLK), .RESET(RESET), .load(load), .quota(quota),
    .XFER_BYTE(xb), .idle(idle));
  // ----------------------------------------------------------------
  // Report and bus tasks
  // ----------------------------------------------------------------
  task results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low, then lets an edge pass
  task bus(bit w, logic [7:0] i, logic [31:0] d, output logic [31:0] v);
    req <= '{read: !w, write: w, address: {i, 2'b00}, writedata: d};
    do @(posedge CLK); while (rsp.waitrequest !== 1'b0);
    v = rsp.readdata;
    req <= '0;
    @(posedge CLK);
  endtask : bus
  task wr(logic [7:0] i, logic [31:0] d);
    logic [31:0] x;
    bus(1, i, d, x);
  endtask : wr
  task rd(logic [7:0] i, output logic [31:0] v);
    bus(0, i, 32'h0000_0000, v);
  endtask : rd
  // ----------------------------------------------------------------
  // Scenario tasks
  // ----------------------------------------------------------------
  // Limits worked out per channel count, mode and interlace
  task lim_case();
    int ch, f, m, k, mn, mx, st, v;
    bit ok;
    logic [31:0] x;
    ch = $urandom % 3; f = $urandom % 2; k = $urandom % 4;
    m = (k == 0) ? 0 : (k >= 2) ? 3 : (($urandom % 2) ? 3 : 0);
    wr(IDX_CONFIG, ch | (m << 2) | (f << 6));
    chk("interlace", f, lace);
    st = 4 << f;
    mn = (k == 0 || k == 3) ? (8 << f) : st;
    mx = (k == 0) ? int'(INST) >> ch : (16384 - 32) >> ch;
    case ($urandom % 5)
      0: v = mn;
      1: v = mx;
      2: v = mx + st;
      3: v = mn - st / 2;
      default: v = mn + st / 2;
    endcase
    ok = v >= mn && v <= mx && v % st == 0 && !(k == 1 && m == 0);
    // Streaming lengths: the top is beyond 32 bits, so only min and step bite
    if (k >= 2) v = int'($urandom >> 1) & (($urandom % 2) ? -st : -1);
    if (k >= 2) ok = v >= mn && v % st == 0;
    wr(IDX_MEMSIZE + k[7:0], v);
    if (ok) sh[k] = v;
    rd(IDX_MEMSIZE + k[7:0], x);
    chk("length", sh[k], x);
    chk("error", !ok, perr);
    wr(IDX_CONTROL, 32'h0000_0002);
  endtask : lim_case
  task hs_check();
    logic [31:0] v;
    rd(IDX_USER_LEN, v);
    chk("user_len", ((moved - freed) / 16) * 16, v);
    rd(IDX_USER_POS, v);
    chk("user_pos", freed % 64, v);
    rd(IDX_CARD_AV, v);
    chk("card_avail", 64 - moved + freed, v);
  endtask : hs_check
  task move(int n);
    quota <= n[7:0];
    load <= 1;
    @(posedge CLK);
    load <= 0;
    @(posedge CLK);
    while (!idle) @(posedge CLK);
    repeat (3) @(posedge CLK);
    moved += n;
  endtask : move
  task give(int n);
    wr(IDX_CARD_LEN, n);
    freed += n;
    hs_check();
  endtask : give
  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    logic [31:0] v;
    void'($urandom(19));
    repeat (4) @(posedge CLK);
    RESET <= 0;
    @(posedge CLK);
    wr(IDX_CONFIG, 32'h0000_0000);
    wr(IDX_MEMSIZE, 32'h0000_0008);
    wr(IDX_CONFIG, 32'h0000_000C);
    wr(IDX_PRE, 32'h0000_0004);
    wr(IDX_LOOPS, 32'h0000_0000);
    sh = '{8, 4, 4, 8};
    repeat (40) lim_case();
    rd(8'h30, v);
    chk("unmapped", 32'h0000_0000, v);
    wr(IDX_CONFIG, 32'h0000_002C);
    wr(IDX_BUFLEN, 32'h0000_0040);
    wr(IDX_NOTIFY, 32'h0000_0010);
    wr(IDX_CONTROL, 32'h0000_0001);
    chk("running", 1, run);
    rd(IDX_STATUS, v);
    chk("status", 32'h0000_0006, v);
    hs_check();
    move(20);
    hs_check();
    give(16);
    move(56);
    hs_check();
    give(48);
    // Low clock enable: offered bytes must leave every counter alone
    CE <= 0;
    move(8);
    moved -= 8;
    CE <= 1;
    hs_check();
    move(16);
    hs_check();
    results();
  end
endmodule : acq_length_limits_and_buffer_handshake_bench
bind acq_limits acq_limits_properties chk_i (.CLK(CLK), .RESET(RESET), .CE(CE),
  .AVM_REQ(AVM_REQ), .XFER_BYTE(XFER_BYTE), .AVM_RSP(AVM_RSP), .INTERLACE(INTERLACE),
  .XFER_ENABLE(XFER_ENABLE), .PARAM_ERROR(PARAM_ERROR));
